// ===== inc/tpp_pkg.sv
// Constants and state types for the 8-bit timer with phase-correct PWM.
// Assumes the byte-wide register port of the timer core and a single I/O clock.
package tpp_pkg;

  // data-space offsets; I/O-space addresses sit below them by IO_OFFSET
  localparam logic [7:0] IO_OFFSET     = 8'h20;
  localparam logic [7:0] ADDR_CTRL_A   = 8'h44;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h45;
  localparam logic [7:0] ADDR_COUNT    = 8'h46;
  localparam logic [7:0] ADDR_CMP_A    = 8'h47;
  localparam logic [7:0] ADDR_CMP_B    = 8'h48;
  localparam logic [7:0] ADDR_FLAGS    = 8'h4F;

  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [7:0] CTRL_A_MASK   = 8'hF3;
  localparam int         OUT_MODE_A_LSB = 6;
  localparam int         OUT_MODE_B_LSB = 4;
  localparam int         WGM_HI_BIT    = 3;
  localparam int         FLAG_OVF_BIT  = 0;
  localparam int         FLAG_CMPA_BIT = 1;
  localparam int         FLAG_CMPB_BIT = 2;

  localparam logic [7:0] BOTTOM        = 8'h00;
  localparam logic [7:0] MAX           = 8'hFF;
  localparam logic [7:0] CNT_STEP      = 8'h01;

  localparam logic [2:0] WGM_NORMAL    = 3'h0;
  localparam logic [2:0] WGM_PC_FF     = 3'h1;
  localparam logic [2:0] WGM_CTC       = 3'h2;
  localparam logic [2:0] WGM_FAST_FF   = 3'h3;
  localparam logic [2:0] WGM_PC_OCR    = 3'h5;
  localparam logic [2:0] WGM_FAST_OCR  = 3'h7;

  localparam logic [1:0] COM_OFF       = 2'h0;
  localparam logic [1:0] COM_TOGGLE    = 2'h1;
  localparam logic [1:0] COM_CLEAR     = 2'h2;
  localparam logic [1:0] COM_SET       = 2'h3;

  // clock select codes and the divider masks they pick (1, 8, 64, 256, 1024)
  localparam logic [2:0] CS_DIV1       = 3'h1;
  localparam logic [2:0] CS_DIV8       = 3'h2;
  localparam logic [2:0] CS_DIV64      = 3'h3;
  localparam logic [2:0] CS_DIV256     = 3'h4;
  localparam logic [2:0] CS_DIV1024    = 3'h5;
  localparam logic [9:0] MASK_DIV1     = 10'h000;
  localparam logic [9:0] MASK_DIV8     = 10'h007;
  localparam logic [9:0] MASK_DIV64    = 10'h03F;
  localparam logic [9:0] MASK_DIV256   = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024  = 10'h3FF;

  typedef struct packed {
    logic [9:0] div;
    logic       tick;
  } tpp_pre_state_type;

  typedef struct packed {
    logic [7:0]      ctrl_a;
    logic            wgm_hi;
    logic [2:0]      clk_sel;
    logic [7:0]      cnt;
    logic            dir_down;
    logic [1:0][7:0] ocr;
    logic [1:0][7:0] ocr_buf;
    logic [1:0]      wave;
    logic [1:0]      cmp_flag;
    logic            ovf;
    logic [7:0]      rdata;
    logic [1:0]      override;
    logic [1:0]      pin;
    logic [1:0]      pin_oe;
  } tpp_state_type;

endpackage : tpp_pkg

// ===== hw/tpp_prescaler.sv
// Prescaler that turns the I/O clock into the timer tick enable.
// Assumes clock select comes from the timer core on the same clock.
`timescale 1ns/10ps
`default_nettype none
module tpp_prescaler
  import tpp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);

  tpp_pre_state_type s_reg;
  tpp_pre_state_type s_next;

  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    case (sel)
      CS_DIV1:    div_mask = MASK_DIV1;
      CS_DIV8:    div_mask = MASK_DIV8;
      CS_DIV64:   div_mask = MASK_DIV64;
      CS_DIV256:  div_mask = MASK_DIV256;
      default:    div_mask = MASK_DIV1024;
    endcase
  endfunction : div_mask

  logic running;
  assign running = (sel_i >= CS_DIV1) && (sel_i <= CS_DIV1024);

  always_comb begin
    s_next = s_reg;
    if (running) begin
      s_next.div  = s_reg.div + 10'h001;
      s_next.tick = (s_reg.div & div_mask(sel_i)) == div_mask(sel_i);
    end else begin
      // stopped clock: restart the divider so the first tick is a full period
      s_next.div  = 10'h000;
      s_next.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;

endmodule : tpp_prescaler
`default_nettype wire

// ===== hw/tpp_timer.sv
// 8-bit timer core: counter, waveform generation for two compare channels,
// register port at data-space or I/O-space addresses, pin override muxing.
// Assumes the CPU register port and the port logic run on clk_i.
// Behaviour
// - modes 0x1 and 0x5 count up to TOP, then down to BOTTOM, repeatedly.
// - phase-correct TOP is 0xFF in mode 0x1, compare A value in mode 0x5.
// - output mode 0x2 clears on up-count match, sets on down-count match.
// - output mode 0x3 sets on up-count match, clears on down-count match.
// - at TOP direction reverses; count holds TOP for exactly one tick.
// - phase-correct mode sets the overflow flag when the counter counts down from 1 to BOTTOM.
// - 8-bit TOP period is 510 ticks; tick is clock over 1/8/64/256/1024.
// - PWM output mode 0x1 toggles A only with high mode bit set.
// - compare A at BOTTOM gives constant low, at MAX constant high, inverted opposite.
// - compare leaving MAX makes the output at MAX the up-count match result.
// - up-counting from above the compare value misses that match, no change.
// - timer is synchronous to the I/O clock, tick acts as enable.
// - a nonzero channel A output mode overrides the pin's port function, except PWM mode 01 with the high mode bit clear.
// - non-PWM output modes 00/01/10/11 disconnect, toggle, clear, set on match.
// - fast PWM 10 clears on match, sets at BOTTOM; 11 the inverse.
// - fast PWM with compare at TOP and upper bit set ignores the match.
// - output mode 00 disconnects A and restores the port in every mode.
// - control A at data offset 0x44, I/O offset 0x24, reset 0x00.
// - control A holds mode A 7:6, mode B 5:4, low mode bits 1:0.
// - waveform mode is two control A bits plus one control B bit.
// - control B at 0x45 holds the high mode bit at bit 3, reset 0x00.
`timescale 1ns/10ps
`default_nettype none
module tpp_timer
  import tpp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_io_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [1:0] port_out_i,
  input  wire logic [1:0] port_dir_i,
  output logic      [1:0] pin_o,
  output logic      [1:0] pin_oe_o,
  output logic      [1:0] override_o,
  output logic      [1:0] wave_out_o,
  output logic            overflow_flag_o
);

  tpp_state_type s_reg;
  tpp_state_type s_next;

  logic       tick;
  logic [2:0] wgm;
  logic       is_pc;
  logic       is_fast;
  logic       is_pwm;
  logic       is_ctc;
  logic [7:0] top_val;
  logic       at_top;
  logic [1:0] out_mode [2];
  logic [1:0] match;
  logic       wr_count;

  // address match in either space; I/O space is the data offset less IO_OFFSET
  function automatic logic reg_hit(input logic [7:0] addr, input logic io,
                                   input logic [7:0] target);
    logic [7:0] eff;
    eff = io ? 8'(addr + IO_OFFSET) : addr;
    reg_hit = (eff == target);
  endfunction : reg_hit

  tpp_prescaler u_prescaler (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .sel_i   (s_reg.clk_sel),
    .tick_o  (tick)
  );

  assign wgm      = {s_reg.wgm_hi, s_reg.ctrl_a[1:0]};
  assign is_pc    = (wgm == WGM_PC_FF) || (wgm == WGM_PC_OCR);
  assign is_fast  = (wgm == WGM_FAST_FF) || (wgm == WGM_FAST_OCR);
  assign is_pwm   = is_pc || is_fast;
  assign is_ctc   = (wgm == WGM_CTC);
  assign top_val  = (wgm == WGM_PC_OCR || wgm == WGM_FAST_OCR || is_ctc) ? s_reg.ocr[0] : MAX;
  assign at_top   = (s_reg.cnt == top_val);
  assign out_mode[0] = s_reg.ctrl_a[OUT_MODE_A_LSB +: 2];
  assign out_mode[1] = s_reg.ctrl_a[OUT_MODE_B_LSB +: 2];
  assign wr_count = reg_wr_i && reg_hit(reg_addr_i, reg_io_i, ADDR_COUNT);

  // only equality matches, so a count above the compare value passes by silently
  assign match[0] = tick && (s_reg.cnt == s_reg.ocr[0]);
  assign match[1] = tick && (s_reg.cnt == s_reg.ocr[1]);

  always_comb begin
    logic up_eff;
    logic toggle_ok;
    logic connected;
    logic ovf_set;
    up_eff    = 1'b0;
    ovf_set   = 1'b0;
    toggle_ok = 1'b0;
    connected = 1'b0;
    s_next    = s_reg;
    s_next.rdata = RESET_BYTE;
    // event only here, so a clear in the same cycle cannot swallow it
    s_next.ovf = 1'b0;

    // counter sequencing, advanced only on the prescaled tick
    if (tick) begin
      if (is_pc) begin
        if (!s_reg.dir_down) begin
          if (at_top) begin
            s_next.dir_down = 1'b1;
            s_next.cnt = (top_val == BOTTOM) ? BOTTOM : s_reg.cnt - CNT_STEP;
            s_next.ocr = s_reg.ocr_buf;
          end else begin
            s_next.cnt = s_reg.cnt + CNT_STEP;
          end
        end else if (s_reg.cnt == BOTTOM) begin
          s_next.dir_down = 1'b0;
          s_next.cnt = s_reg.cnt + CNT_STEP;
        end else begin
          s_next.cnt = s_reg.cnt - CNT_STEP;
          if (s_reg.cnt == CNT_STEP) begin
            s_next.ovf = 1'b1;
          end
        end
      end else if (is_fast) begin
        s_next.dir_down = 1'b0;
        if (at_top) begin
          s_next.cnt = BOTTOM;
          s_next.ocr = s_reg.ocr_buf;
          s_next.ovf = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + CNT_STEP;
        end
      end else begin
        s_next.dir_down = 1'b0;
        if (is_ctc && at_top) begin
          s_next.cnt = BOTTOM;
        end else begin
          s_next.cnt = s_reg.cnt + CNT_STEP;
        end
        if (s_reg.cnt == MAX) begin
          s_next.ovf = 1'b1;
        end
      end
    end
    ovf_set    = s_next.ovf;
    s_next.ovf = s_reg.ovf || ovf_set;

    // waveform per channel; channel 1 never gets the PWM toggle
    for (int ch = 0; ch < 2; ch++) begin
      toggle_ok = (ch == 0) && s_reg.wgm_hi;
      up_eff = (s_reg.cnt == BOTTOM) || (!s_reg.dir_down && !at_top);
      if (match[ch]) begin
        s_next.cmp_flag[ch] = 1'b1;
      end
      if (!is_pwm) begin
        if (match[ch]) begin
          case (out_mode[ch])
            COM_TOGGLE: s_next.wave[ch] = ~s_reg.wave[ch];
            COM_CLEAR:  s_next.wave[ch] = 1'b0;
            COM_SET:    s_next.wave[ch] = 1'b1;
            default:    s_next.wave[ch] = s_reg.wave[ch];
          endcase
        end
      end else if (out_mode[ch] == COM_TOGGLE) begin
        if (match[ch] && toggle_ok) begin
          s_next.wave[ch] = ~s_reg.wave[ch];
        end
      end else if (out_mode[ch][1]) begin
        if (is_fast) begin
          // a match at TOP would fight the BOTTOM action, so it is dropped
          if (match[ch] && !(s_reg.ocr[ch] == top_val)) begin
            s_next.wave[ch] = out_mode[ch][0];
          end
          if (tick && at_top) begin
            s_next.wave[ch] = ~out_mode[ch][0];
          end
        end else begin
          // BOTTOM counts as up and TOP as down, giving the constant extremes
          if (match[ch]) begin
            s_next.wave[ch] = up_eff ? out_mode[ch][0] : ~out_mode[ch][0];
          end
          if (tick && at_top && !s_reg.dir_down && s_reg.ocr[ch] == MAX &&
              s_reg.ocr_buf[ch] != MAX) begin
            s_next.wave[ch] = out_mode[ch][0];
          end
        end
      end
      connected = (out_mode[ch] != COM_OFF) &&
                  !(is_pwm && out_mode[ch] == COM_TOGGLE && !toggle_ok);
      s_next.override[ch] = connected;
      s_next.pin[ch]      = connected ? s_next.wave[ch] : port_out_i[ch];
      s_next.pin_oe[ch]   = port_dir_i[ch];
    end

    // register writes; a software write to the count beats counting
    if (reg_wr_i) begin
      if (reg_hit(reg_addr_i, reg_io_i, ADDR_CTRL_A)) begin
        s_next.ctrl_a = reg_wdata_i & CTRL_A_MASK;
      end
      if (reg_hit(reg_addr_i, reg_io_i, ADDR_CTRL_B)) begin
        s_next.wgm_hi  = reg_wdata_i[WGM_HI_BIT];
        s_next.clk_sel = reg_wdata_i[2:0];
      end
      if (wr_count) begin
        s_next.cnt = reg_wdata_i;
      end
      if (reg_hit(reg_addr_i, reg_io_i, ADDR_CMP_A)) begin
        s_next.ocr_buf[0] = reg_wdata_i;
        if (!is_pwm) begin
          s_next.ocr[0] = reg_wdata_i;
        end
      end
      if (reg_hit(reg_addr_i, reg_io_i, ADDR_CMP_B)) begin
        s_next.ocr_buf[1] = reg_wdata_i;
        if (!is_pwm) begin
          s_next.ocr[1] = reg_wdata_i;
        end
      end
      // write one to clear; a flag set in the same cycle survives
      if (reg_hit(reg_addr_i, reg_io_i, ADDR_FLAGS)) begin
        s_next.ovf = (s_reg.ovf && !reg_wdata_i[FLAG_OVF_BIT]) || ovf_set;
        s_next.cmp_flag[0] = (s_reg.cmp_flag[0] && !reg_wdata_i[FLAG_CMPA_BIT]) || match[0];
        s_next.cmp_flag[1] = (s_reg.cmp_flag[1] && !reg_wdata_i[FLAG_CMPB_BIT]) || match[1];
      end
    end

    if (reg_rd_i) begin
      if (reg_hit(reg_addr_i, reg_io_i, ADDR_CTRL_A)) begin
        s_next.rdata = s_reg.ctrl_a;
      end else if (reg_hit(reg_addr_i, reg_io_i, ADDR_CTRL_B)) begin
        s_next.rdata = {4'h0, s_reg.wgm_hi, s_reg.clk_sel};
      end else if (reg_hit(reg_addr_i, reg_io_i, ADDR_COUNT)) begin
        s_next.rdata = s_reg.cnt;
      end else if (reg_hit(reg_addr_i, reg_io_i, ADDR_CMP_A)) begin
        s_next.rdata = s_reg.ocr_buf[0];
      end else if (reg_hit(reg_addr_i, reg_io_i, ADDR_CMP_B)) begin
        s_next.rdata = s_reg.ocr_buf[1];
      end else if (reg_hit(reg_addr_i, reg_io_i, ADDR_FLAGS)) begin
        s_next.rdata = {5'h00, s_reg.cmp_flag, s_reg.ovf};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_o     = s_reg.rdata;
  assign pin_o           = s_reg.pin;
  assign pin_oe_o        = s_reg.pin_oe;
  assign override_o      = s_reg.override;
  assign wave_out_o      = s_reg.wave;
  assign overflow_flag_o = s_reg.ovf;

  property p_pc_up_step;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && is_pc && !s_reg.dir_down && !at_top && !wr_count)
      |=> (s_reg.cnt == 8'($past(s_reg.cnt) + CNT_STEP));
  endproperty
  a_pc_up_step: assert property (p_pc_up_step) else $error("up-count step wrong");

  property p_top_once;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && is_pc && !s_reg.dir_down && at_top && top_val != BOTTOM && !wr_count)
      |=> (s_reg.dir_down && s_reg.cnt == 8'($past(s_reg.cnt) - CNT_STEP));
  endproperty
  a_top_once: assert property (p_top_once) else $error("no turn at TOP");

  property p_ovf_bottom;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && is_pc && s_reg.dir_down && s_reg.cnt == CNT_STEP && !wr_count)
      |=> (s_reg.ovf && s_reg.cnt == BOTTOM);
  endproperty
  a_ovf_bottom: assert property (p_ovf_bottom) else $error("overflow missing at BOTTOM");

  property p_clr_up;
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_pc && out_mode[0] == COM_CLEAR && match[0] && !s_reg.dir_down && !at_top)
      |=> !s_reg.wave[0];
  endproperty
  a_clr_up: assert property (p_clr_up) else $error("up match did not clear");

  property p_set_up;
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_pc && out_mode[0] == COM_SET && match[0] && !s_reg.dir_down && !at_top)
      |=> s_reg.wave[0];
  endproperty
  a_set_up: assert property (p_set_up) else $error("inverted up match did not set");

  property p_fast_bottom;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && is_fast && out_mode[0] == COM_CLEAR && at_top) |=> s_reg.wave[0];
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast PWM not set at BOTTOM");

  property p_disconnect;
    @(posedge clk_i) disable iff (!rst_n_i)
    (out_mode[0] == COM_OFF) |=> (!s_reg.override[0] && s_reg.pin[0] == $past(port_out_i[0]));
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("pin A not returned to port");

  property p_override;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!is_pwm && out_mode[0] != COM_OFF) |=> s_reg.override[0];
  endproperty
  a_override: assert property (p_override) else $error("pin A not overridden");

  property p_ctrl_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_hit(reg_addr_i, reg_io_i, ADDR_CTRL_A))
      |=> (s_reg.ctrl_a == ($past(reg_wdata_i) & CTRL_A_MASK));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control A write wrong");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!tick && !wr_count) |=> $stable(s_reg.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without tick");

  property p_max_leave;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && is_pc && out_mode[0][1] && !s_reg.dir_down && at_top &&
     s_reg.ocr[0] == MAX && s_reg.ocr_buf[0] != MAX)
      |=> (s_reg.wave[0] == $past(s_reg.ctrl_a[OUT_MODE_A_LSB]));
  endproperty
  a_max_leave: assert property (p_max_leave) else $error("no symmetric level at MAX");

  property p_fast_top;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick && is_fast && out_mode[0][1] && s_reg.ocr[0] == top_val && at_top)
      |=> (s_reg.wave[0] == !$past(s_reg.ctrl_a[OUT_MODE_A_LSB]));
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("match at TOP not ignored");

  property p_b_no_toggle;
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_pwm && out_mode[1] == COM_TOGGLE) |=> !s_reg.override[1];
  endproperty
  a_b_no_toggle: assert property (p_b_no_toggle) else $error("pin B toggle connected");

endmodule : tpp_timer
`default_nettype wire

// ===== test/tpp_load.sv
// Load on the two compare output pins, plus the software port settings.
// Assumes pin and enable come straight from the timer; lines have pull-downs.
`timescale 1ns/10ps
`default_nettype none
module tpp_load (
  input  wire logic [1:0] dir_i,
  input  wire logic [1:0] out_i,
  input  wire logic [1:0] pin_i,
  input  wire logic [1:0] pin_oe_i,
  output logic      [1:0] port_dir_o,
  output logic      [1:0] port_out_o,
  output logic      [1:0] line_o
);
  // without the direction bit the wave never reaches the line
  assign port_dir_o = dir_i;
  assign port_out_o = out_i;
  // an undriven line falls to its pull-down
  assign line_o = pin_i & pin_oe_i;
endmodule : tpp_load
`default_nettype wire

// ===== test/tpp_timer_tb.sv
// Self-checking bench for the timer with phase-correct PWM.
// Assumes the pin load model and a 50 MHz I/O clock.
`timescale 1ns/10ps
`default_nettype none
module tpp_timer_tb
  import tpp_pkg::*;
;
  typedef struct packed {
    logic [7:0] wa;
    logic       wio;
    logic [7:0] wd;
    logic [7:0] ra;
    logic       rio;
    logic [7:0] ex;
  } tpp_row_type;

  logic       clk_i       = 1'b0;
  logic       rst_n_i     = 1'b0;
  logic [7:0] reg_addr_i  = 8'h00;
  logic       reg_io_i    = 1'b0;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [1:0] dir_sw      = 2'h3;
  logic [1:0] out_sw      = 2'h0;
  logic [7:0] reg_rdata_o;
  logic [1:0] port_out_i;
  logic [1:0] port_dir_i;
  logic [1:0] pin_o;
  logic [1:0] pin_oe_o;
  logic [1:0] override_o;
  logic [1:0] wave_out_o;
  logic [1:0] line;
  logic       overflow_flag_o;
  int         failures    = 0;
  int         compares    = 0;
  int         hi;
  int         lo;
  tpp_row_type rows [6] = '{
    '{8'h44, 1'b0, 8'hFF, 8'h44, 1'b0, 8'hF3},
    '{8'h24, 1'b1, 8'h00, 8'h44, 1'b0, 8'h00},
    '{8'h45, 1'b0, 8'hFF, 8'h25, 1'b1, 8'h0F},
    '{8'h45, 1'b0, 8'h00, 8'h45, 1'b0, 8'h00},
    '{8'h50, 1'b0, 8'hAA, 8'h50, 1'b0, 8'h00},
    '{8'h47, 1'b0, 8'h5A, 8'h47, 1'b0, 8'h5A}};

  always #10 clk_i = ~clk_i;

  tpp_timer u_tpp_timer (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .reg_addr_i     (reg_addr_i),
    .reg_io_i       (reg_io_i),
    .reg_wr_i       (reg_wr_i),
    .reg_rd_i       (reg_rd_i),
    .reg_wdata_i    (reg_wdata_i),
    .reg_rdata_o    (reg_rdata_o),
    .port_out_i     (port_out_i),
    .port_dir_i     (port_dir_i),
    .pin_o          (pin_o),
    .pin_oe_o       (pin_oe_o),
    .override_o     (override_o),
    .wave_out_o     (wave_out_o),
    .overflow_flag_o(overflow_flag_o)
  );

  tpp_load u_tpp_load (
    .dir_i     (dir_sw),
    .out_i     (out_sw),
    .pin_i     (pin_o),
    .pin_oe_i  (pin_oe_o),
    .port_dir_o(port_dir_i),
    .port_out_o(port_out_i),
    .line_o    (line)
  );

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
    end
  endtask : step

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // strobe drops a cycle before the next access may raise it again
  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    reg_addr_i = a;
    reg_io_i = io;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step(1);
    reg_wr_i = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] q);
    reg_addr_i = a;
    reg_io_i = io;
    reg_rd_i = 1'b1;
    step(1);
    reg_rd_i = 1'b0;
    q = reg_rdata_o;
    step(1);
  endtask : rd

  // stop, load compare while immediate, clear count, then start
  task automatic cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] cmp);
    wr(ADDR_CTRL_B, 1'b0, 8'h00);
    wr(ADDR_CTRL_A, 1'b0, 8'h00);
    wr(ADDR_CMP_A, 1'b0, cmp);
    wr(ADDR_COUNT, 1'b0, 8'h00);
    wr(ADDR_CTRL_A, 1'b0, ca);
    wr(ADDR_CTRL_B, 1'b0, cb);
  endtask : cfg

  // one full high phase and the following low phase of line A
  task automatic meas();
    int n;
    n = 0;
    while (line[0] !== 1'b0 && n < 9000) begin
      step(1);
      n++;
    end
    while (line[0] !== 1'b1 && n < 9000) begin
      step(1);
      n++;
    end
    hi = 0;
    lo = 0;
    while (line[0] === 1'b1 && hi < 9000) begin
      step(1);
      hi++;
    end
    while (line[0] === 1'b0 && lo < 9000) begin
      step(1);
      lo++;
    end
  endtask : meas

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    #(20 * 80000);
    failures++;
    end_sim();
  end

  initial begin
    logic [7:0] q;
    int         k;
    repeat (6) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    step(1);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wio, rows[i].wd);
      rd(rows[i].ra, rows[i].rio, q);
      chk("reg", 16'(q), 16'(rows[i].ex));
    end
    $display("test registers done");
    cfg(8'h81, 8'h01, 8'h80);
    meas();
    chk("pc_period", 16'(hi + lo), 16'h01FE);
    chk("pc_low", 16'(lo), 16'h00FE);
    chk("override", 16'(override_o), 16'h0001);
    chk("pin_oe", 16'(pin_oe_o), 16'h0003);
    chk("ovf", 16'(overflow_flag_o), 16'h0001);
    wr(ADDR_FLAGS, 1'b0, 8'h01);
    chk("ovf_clr", 16'(overflow_flag_o), 16'h0000);
    k = 0;
    while (overflow_flag_o !== 1'b1 && k < 600) begin
      step(1);
      k++;
    end
    chk("ovf_bottom", 16'(k < 140), 16'h0001);
    cfg(8'hC1, 8'h01, 8'h80);
    meas();
    chk("pc_inv_high", 16'(hi), 16'h00FE);
    $display("test phase correct done");
    // divided tick stretches the period eightfold
    cfg(8'h81, 8'h02, 8'h80);
    meas();
    chk("div8_period", 16'(hi + lo), 16'h0FF0);
    $display("test prescale done");
    cfg(8'h41, 8'h09, 8'h10);
    meas();
    chk("tog_high", 16'(hi), 16'h0020);
    chk("tog_low", 16'(lo), 16'h0020);
    cfg(8'h51, 8'h01, 8'h10);
    step(2);
    chk("tog_off", 16'(override_o), 16'h0000);
    $display("test toggle done");
    for (k = 0; k < 4; k++) begin
      cfg(k[1] ? 8'hC1 : 8'h81, 8'h01, k[0] ? 8'hFF : 8'h00);
      step(520);
      hi = 0;
      repeat (520) begin
        step(1);
        hi += int'(line[0] === 1'b1);
      end
      chk("extreme", 16'(hi), (k[1] ^ k[0]) ? 16'h0208 : 16'h0000);
    end
    $display("test extremes done");
    // compare leaving MAX: low from TOP down to the match, 0xFE to 0x80
    cfg(8'h81, 8'h01, 8'hFF);
    step(520);
    chk("wave_a", 16'(wave_out_o), 16'h0001);
    wr(ADDR_CMP_A, 1'b0, 8'h80);
    k = 0;
    while (line[0] !== 1'b0 && k < 600) begin
      step(1);
      k++;
    end
    lo = 0;
    while (line[0] === 1'b0 && lo < 600) begin
      step(1);
      lo++;
    end
    chk("max_leave", 16'(lo), 16'h007F);
    $display("test max leave done");
    cfg(8'h42, 8'h01, 8'h0F);
    meas();
    chk("ctc_toggle", 16'(hi + lo), 16'h0020);
    for (k = 0; k < 2; k++) begin
      cfg(k[0] ? 8'h82 : 8'hC2, 8'h01, 8'h0F);
      step(40);
      chk("ctc_level", 16'(line[0]), k[0] ? 16'h0000 : 16'h0001);
    end
    $display("test non pwm done");
    cfg(8'h83, 8'h01, 8'h40);
    meas();
    chk("fast_high", 16'(hi), 16'h0041);
    chk("fast_period", 16'(hi + lo), 16'h0100);
    // compare at TOP: match dropped, BOTTOM set keeps the line high
    cfg(8'h83, 8'h01, 8'hFF);
    step(300);
    hi = 0;
    repeat (256) begin
      step(1);
      hi += int'(line[0] === 1'b1);
    end
    chk("fast_max", 16'(hi), 16'h0100);
    $display("test fast pwm done");
    cfg(8'h01, 8'h01, 8'h40);
    out_sw = 2'h1;
    step(3);
    chk("port_hi", 16'(pin_o), 16'h0001);
    out_sw = 2'h0;
    step(3);
    chk("port_lo", 16'(pin_o), 16'h0000);
    $display("test disconnect done");
    rst_n_i = 1'b0;
    step(2);
    rst_n_i = 1'b1;
    step(1);
    chk("rst_ovf", 16'(overflow_flag_o), 16'h0000);
    rd(ADDR_CTRL_A, 1'b0, q);
    chk("rst_ctrl_a", 16'(q), 16'h0000);
    rd(8'h25, 1'b1, q);
    chk("rst_ctrl_b", 16'(q), 16'h0000);
    $display("test reset done");
    end_sim();
  end
endmodule : tpp_timer_tb
`default_nettype wire
